//--- pat_capture_chan.sv
// one input capture channel: pin synchroniser, edge detect, value and flag
`timescale 1ns/1ns
`default_nettype none
module pat_capture_chan (
    input  wire logic       clk,        // cpu clock
    input  wire logic       rst_n,      // async reset, active low
    input  wire logic       cap_pin,    // raw capture pin
    input  wire logic       edge_rise,  // 1 rising, 0 falling
    input  wire logic [7:0] count,      // live counter value
    input  wire logic       flag_clr,   // value register read this cycle
    output logic            flag,       // capture flag
    output logic [7:0]      value       // captured count
);
    // ==========================================================
    // synchroniser and edge detector
    logic       sync_a;                 // first stage, read only by sync_b
    logic       sync_b;                 // second stage
    logic       sync_c;                 // delayed copy for edges
    logic       edge_hit;               // selected edge seen
    logic       next_flag;              // flag next value

    // two flops before any logic looks at the pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end else begin
            sync_a <= cap_pin;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // one clean edge gives one event
    assign edge_hit  = edge_rise ? (sync_b & ~sync_c) : (~sync_b & sync_c);
    // a pending flag inhibits new transfers; clear wins, an edge in the clearing cycle is dropped
    assign next_flag = (edge_hit & ~flag) | (flag & ~flag_clr);

    // ==========================================================
    // value register, only hardware writes it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag  <= 1'b0;
            value <= pat_pkg::REG_RESET;
        end else begin
            flag <= next_flag;
            if (edge_hit && !flag) begin
                value <= count;
            end
        end
    end

    // a pending capture keeps value frozen until read
    chk_flag_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (flag && !flag_clr) |=> (flag && $stable(value)))
        else $error("capture flag or value changed while pending");
    chk_capture_load: assert property (@(posedge clk) disable iff (!rst_n)
        (edge_hit && !flag) |=> (flag && value == $past(count)))
        else $error("capture did not latch the count");
endmodule : pat_capture_chan
`default_nettype wire

//--- pat_pin_model.sv
// pin-side model: capture pin levels and a slow external clock
`timescale 1ns/1ns
`default_nettype none
module pat_pin_model (
    input  wire logic       clk,     // cpu clock
    input  wire logic [1:0] cap_lvl, // requested capture levels
    input  wire logic       ext_run, // lets the external clock toggle
    output logic [1:0]      cap_pin, // capture pins ch2,ch1
    output logic            ext_clk  // external clock, still when idle
);
    logic [1:0] div; // divider, keeps ext clock far below half cpu rate
    // ==========================================================
    // start-up levels
    initial begin
        div = 2'h0;
        ext_clk = 1'b0;
        cap_pin = 2'h2;
    end
    // ==========================================================
    // pin drive, changes just after the cpu edge
    always @(posedge clk) begin
        cap_pin <= cap_lvl; // edge appears one clock after request
        div <= ext_run ? div + 2'h1 : 2'h0;
        if (ext_run && div == 2'h3) begin
            ext_clk <= ~ext_clk; // one toggle every four clocks
        end
    end
endmodule : pat_pin_model
`default_nettype wire

//--- pat_pkg.sv
// constants shared by the auto-reload pwm timer and its capture channels
package pat_pkg;
    // ==========================================================
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_DUTY3   = 8'h73; // duty cycle ch3
    localparam logic [7:0] IDX_DUTY2   = 8'h74; // duty cycle ch2
    localparam logic [7:0] IDX_DUTY1   = 8'h75; // duty cycle ch1
    localparam logic [7:0] IDX_DUTY0   = 8'h76; // duty cycle ch0
    localparam logic [7:0] IDX_OCTL    = 8'h77; // output control
    localparam logic [7:0] IDX_CSR     = 8'h78; // timer control/status
    localparam logic [7:0] IDX_CAR     = 8'h79; // counter access
    localparam logic [7:0] IDX_ARR     = 8'h7a; // auto-reload value
    localparam logic [7:0] IDX_CCSR    = 8'h7b; // capture control/status
    localparam logic [7:0] IDX_CAPV1   = 8'h7c; // capture value ch1
    localparam logic [7:0] IDX_CAPV2   = 8'h7d; // capture value ch2

    // ==========================================================
    // timer control/status fields
    localparam int          CSR_EXTERNAL_CLOCK_SELECT   = 7;     // external clock select
    localparam int          CSR_CC_LO  = 4;     // prescale select low bit
    localparam int          CSR_TCE    = 3;     // counter run
    localparam int          CSR_FORCE_RELOAD   = 2;     // force reload, write-only
    localparam int          CSR_OIE    = 1;     // overflow irq enable
    localparam int          CSR_OVF    = 0;     // overflow flag

    // ==========================================================
    // output control and capture control fields
    localparam int          OCTL_OE_LO = 4;     // output enables [7:4]
    localparam int          CCSR_CS_LO = 4;     // edge selects [5:4]
    localparam int          CCSR_CIE_LO = 2;    // capture irq enables [3:2]

    // ==========================================================
    // widths, counts and reset values
    localparam int          NUM_PWM    = 4;     // pwm channels
    localparam int          NUM_CAP    = 2;     // capture channels
    localparam logic [7:0]  CNT_TOP    = 8'hff; // top count before reload
    localparam logic [7:0]  REG_RESET  = 8'h00; // every register resets here
    localparam logic [6:0]  PSC_RESET  = 7'h00; // cleared prescaler
    localparam logic [23:0] RD_PAD     = 24'h000000; // upper read lanes
endpackage : pat_pkg

//--- pat_timer.sv
// 8-bit auto-reload pwm timer with four pwm outputs and two captures
// Overview of operation
// - force reload reads zero, reloads, clears prescaler
// - overflow irq only when enabled and flagged
// - overflow flag set on top rollover, read clears
// - counter access reads live count, writes overwrite
// - overflow loads auto-reload value into counter
// - overflow switches outputs to polarity start level
// - upper output control nibble enables each channel
// - high at or below compare, polarity inverts
// - polarity change inverts output at once
// - duty sets second edge, reload first edge
// - capture control top two bits read zero
// - edge select: zero falling, one rising
// - per-channel capture irq enable
// - capture sets flag, value read clears it
// - capture value read-only, holds captured count
// - reload value sets frequency and resolution
// - all registers reset to zero
// - prescaler divides by two to prescale select
// - run bit zero freezes counter and prescaler
// - external clock select picks prescaler source
// - compare shadows load from duty on overflow
`timescale 1ns/1ns
`default_nettype none
module pat_timer (
    input  wire logic        REF_CLK,     // cpu clock, 100 MHz
    input  wire logic        RST_N,       // async reset, active low
    input  wire logic [9:0]  ADDRESS,     // avalon byte address
    input  wire logic        READ,        // avalon read
    input  wire logic        WRITE,       // avalon write
    input  wire logic [3:0]  BYTEENABLE,  // avalon byte enables
    input  wire logic [31:0] WRITEDATA,   // avalon write data
    output logic [31:0]      READDATA,    // avalon read data
    output logic             WAITREQUEST, // avalon wait, low answers
    input  wire logic        EXT_CLK,     // external prescaler clock pin
    input  wire logic [1:0]  CAP_IN,      // capture pins ch2,ch1
    output logic [3:0]       PWM_OUT,     // pwm pin levels
    output logic [3:0]       PWM_OE,      // pwm pin drive enables
    output logic             OVF_IRQ,     // overflow interrupt request
    output logic [1:0]       CAP_IRQ      // capture interrupt requests
);
    // ==========================================================
    // register state
    logic [7:0] duty [0:3];               // duty cycle per channel
    logic [7:0] shadow [0:3];             // hidden compare per channel
    logic [7:0] octl;                     // output control
    logic       external_clock_select;                     // external clock select
    logic [2:0] cc;                       // prescale select
    logic       run;                      // counter run
    logic       overflow_irq_enable;                      // overflow irq enable
    logic       ovf;                      // overflow flag
    logic [7:0] arr;                      // auto-reload value
    logic [1:0] cs;                       // capture edge selects
    logic [1:0] cie;                      // capture irq enables
    logic [7:0] cnt;                      // counter
    logic [6:0] presc;                    // prescaler

    // ==========================================================
    // bus handshake and decode
    logic [7:0] addr_idx;                 // register index
    logic       req;                      // request present
    logic       fire;                     // request completes this edge
    logic       wr_fire;                  // write with low lane enabled
    logic       rd_fire;                  // read completes
    logic [7:0] wdata;                    // low write byte
    logic       hit_octl;                 // decode strobes
    logic       hit_csr;
    logic       hit_car;
    logic       hit_arr;
    logic       hit_ccsr;
    logic       hit_capv1;
    logic       hit_capv2;
    logic [7:0] rd_mux;                   // selected read byte

    assign addr_idx  = ADDRESS[9:2];
    assign req       = READ | WRITE;
    assign fire      = req & ~WAITREQUEST;
    assign wr_fire   = fire & WRITE & BYTEENABLE[0];
    assign rd_fire   = fire & READ;
    assign wdata     = WRITEDATA[7:0];
    assign hit_octl  = (addr_idx == pat_pkg::IDX_OCTL);
    assign hit_csr   = (addr_idx == pat_pkg::IDX_CSR);
    assign hit_car   = (addr_idx == pat_pkg::IDX_CAR);
    assign hit_arr   = (addr_idx == pat_pkg::IDX_ARR);
    assign hit_ccsr  = (addr_idx == pat_pkg::IDX_CCSR);
    assign hit_capv1 = (addr_idx == pat_pkg::IDX_CAPV1);
    assign hit_capv2 = (addr_idx == pat_pkg::IDX_CAPV2);

    // ==========================================================
    // capture channels
    logic [1:0] cap_flag;                 // capture flags ch2,ch1
    logic [7:0] cap_val [0:1];            // captured counts
    logic [1:0] cap_clr;                  // value register reads

    assign cap_clr = {rd_fire & hit_capv2, rd_fire & hit_capv1};

    pat_capture_chan u_cap1 (
        .clk       (REF_CLK),
        .rst_n     (RST_N),
        .cap_pin   (CAP_IN[0]),
        .edge_rise (cs[0]),
        .count     (cnt),
        .flag_clr  (cap_clr[0]),
        .flag      (cap_flag[0]),
        .value     (cap_val[0])
    );

    pat_capture_chan u_cap2 (
        .clk       (REF_CLK),
        .rst_n     (RST_N),
        .cap_pin   (CAP_IN[1]),
        .edge_rise (cs[1]),
        .count     (cnt),
        .flag_clr  (cap_clr[1]),
        .flag      (cap_flag[1]),
        .value     (cap_val[1])
    );

    // ==========================================================
    // read multiplexer
    always_comb begin
        rd_mux = pat_pkg::REG_RESET; // unmapped reads as zero
        if (addr_idx == pat_pkg::IDX_DUTY3) begin
            rd_mux = duty[3];
        end else if (addr_idx == pat_pkg::IDX_DUTY2) begin
            rd_mux = duty[2];
        end else if (addr_idx == pat_pkg::IDX_DUTY1) begin
            rd_mux = duty[1];
        end else if (addr_idx == pat_pkg::IDX_DUTY0) begin
            rd_mux = duty[0];
        end else if (hit_octl) begin
            rd_mux = octl;
        end else if (hit_csr) begin
            rd_mux = {external_clock_select, cc, run, 1'b0, overflow_irq_enable, ovf};
        end else if (hit_car) begin
            rd_mux = cnt;
        end else if (hit_arr) begin
            rd_mux = arr;
        end else if (hit_ccsr) begin
            rd_mux = {2'b00, cs, cie, cap_flag};
        end else if (hit_capv1) begin
            rd_mux = cap_val[0];
        end else if (hit_capv2) begin
            rd_mux = cap_val[1];
        end
    end

    // one wait cycle per request, data loaded with the answer
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            WAITREQUEST <= 1'b1;
            READDATA    <= 32'h00000000;
        end else begin
            WAITREQUEST <= ~(req & WAITREQUEST);
            if (req && WAITREQUEST) begin
                READDATA <= {pat_pkg::RD_PAD, rd_mux};
            end
        end
    end

    // ==========================================================
    // clock source: external pin synchronised, rising edge counted
    logic ext_a;                          // first stage, read only by ext_b
    logic ext_b;                          // second stage
    logic ext_c;                          // delayed copy
    logic src_tick;                       // prescaler input pulse
    logic [6:0] psc_mask;                 // prescale tap mask
    logic cnt_tick;                       // counter advance

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ext_a <= 1'b0;
            ext_b <= 1'b0;
            ext_c <= 1'b0;
        end else begin
            ext_a <= EXT_CLK;
            ext_b <= ext_a;
            ext_c <= ext_b;
        end
    end

    assign src_tick = external_clock_select ? (ext_b & ~ext_c) : 1'b1;
    assign psc_mask = 7'((8'h01 << cc) - 8'h01);
    assign cnt_tick = run & src_tick & ((presc & psc_mask) == psc_mask);

    // ==========================================================
    // counter, prescaler and overflow
    logic       wr_car;                   // counter access write
    logic       wr_force;                 // force reload write
    logic       ovf_evt;                  // rollover from top
    logic       ovf_clr;                  // flag read as set
    logic [7:0] next_cnt;                 // counter next value
    logic [6:0] next_presc;               // prescaler next value

    assign wr_car   = wr_fire & hit_car;
    assign wr_force = wr_fire & hit_csr & wdata[pat_pkg::CSR_FORCE_RELOAD];
    assign ovf_evt  = cnt_tick & (cnt == pat_pkg::CNT_TOP) & ~wr_car & ~wr_force;
    assign ovf_clr  = rd_fire & hit_csr & READDATA[pat_pkg::CSR_OVF];

    // write wins over reload, reload over counting
    always_comb begin
        next_cnt   = cnt;
        next_presc = presc;
        if (wr_car) begin
            next_cnt   = wdata;
            next_presc = pat_pkg::PSC_RESET;
        end else if (wr_force) begin
            next_cnt   = arr;
            next_presc = pat_pkg::PSC_RESET;
        end else if (run && src_tick) begin
            next_presc = 7'(presc + 7'h01);
            if (ovf_evt) begin
                next_cnt = arr;
            end else if (cnt_tick) begin
                next_cnt = 8'(cnt + 8'h01);
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt   <= pat_pkg::REG_RESET;
            presc <= pat_pkg::PSC_RESET;
            ovf   <= 1'b0;
        end else begin
            cnt   <= next_cnt;
            presc <= next_presc;
            ovf   <= ovf_evt | (ovf & ~ovf_clr);
        end
    end

    // ==========================================================
    // software-written registers
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < pat_pkg::NUM_PWM; i++) begin
                duty[i] <= pat_pkg::REG_RESET;
            end
            octl <= pat_pkg::REG_RESET;
            external_clock_select <= 1'b0;
            cc   <= 3'h0;
            run  <= 1'b0;
            overflow_irq_enable  <= 1'b0;
            arr  <= pat_pkg::REG_RESET;
            cs   <= 2'h0;
            cie  <= 2'h0;
        end else if (wr_fire) begin
            for (int i = 0; i < pat_pkg::NUM_PWM; i++) begin
                if (addr_idx == 8'(pat_pkg::IDX_DUTY0 - 8'(i))) begin
                    duty[i] <= wdata;
                end
            end
            if (hit_octl) begin
                octl <= wdata;
            end
            if (hit_csr) begin
                external_clock_select <= wdata[pat_pkg::CSR_EXTERNAL_CLOCK_SELECT];
                cc   <= wdata[pat_pkg::CSR_CC_LO +: 3];
                run  <= wdata[pat_pkg::CSR_TCE];
                overflow_irq_enable  <= wdata[pat_pkg::CSR_OIE];
            end
            if (hit_arr) begin
                arr <= wdata;
            end
            if (hit_ccsr) begin
                cs  <= wdata[pat_pkg::CCSR_CS_LO +: 2];
                cie <= wdata[pat_pkg::CCSR_CIE_LO +: 2];
            end
        end
    end

    // ==========================================================
    // compare shadows and pwm pins
    logic [3:0] next_pwm;                 // pin level before the flop

    always_comb begin
        for (int i = 0; i < pat_pkg::NUM_PWM; i++) begin
            // reload value is first edge, compare is second
            next_pwm[i] = octl[pat_pkg::OCTL_OE_LO + i]
                        & ((cnt <= shadow[i]) ^ octl[i]);
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < pat_pkg::NUM_PWM; i++) begin
                shadow[i] <= pat_pkg::REG_RESET;
            end
        end else if (ovf_evt) begin
            for (int i = 0; i < pat_pkg::NUM_PWM; i++) begin
                shadow[i] <= duty[i];
            end
        end
    end

    // outputs and interrupt requests, all registered
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PWM_OUT <= 4'h0;
            PWM_OE  <= 4'h0;
            OVF_IRQ <= 1'b0;
            CAP_IRQ <= 2'h0;
        end else begin
            PWM_OUT <= next_pwm;
            PWM_OE  <= octl[pat_pkg::OCTL_OE_LO +: 4];
            OVF_IRQ <= overflow_irq_enable & ovf;
            CAP_IRQ <= cie & cap_flag;
        end
    end

    // ==========================================================
    // checks
    chk_force_reads_zero: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (rd_fire && hit_csr) |-> (READDATA[pat_pkg::CSR_FORCE_RELOAD] == 1'b0))
        else $error("force reload bit read back as one");
    chk_ovf_irq_gate: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        ##1 (OVF_IRQ == ($past(overflow_irq_enable) && $past(ovf))))
        else $error("overflow request does not follow enable and flag");
    chk_ovf_set: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        ovf_evt |=> ovf)
        else $error("overflow flag lost");
    chk_car_write: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        wr_car |=> (cnt == $past(wdata) && presc == pat_pkg::PSC_RESET))
        else $error("counter write not applied");
    chk_reload_value: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        ovf_evt |=> (cnt == $past(arr)))
        else $error("overflow did not reload counter");
    chk_shadow_load: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        ovf_evt |=> (shadow[0] == $past(duty[0]) && shadow[3] == $past(duty[3])))
        else $error("compare shadow not loaded on overflow");
    chk_run_freeze: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (!run && !wr_car && !wr_force) |=> ($stable(cnt) && $stable(presc)))
        else $error("counter moved while stopped");
    chk_pwm_polarity: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (octl[pat_pkg::OCTL_OE_LO] && !octl[0] && cnt <= shadow[0]) |=> PWM_OUT[0])
        else $error("channel 0 low at or below compare");
    chk_ccsr_reserved: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (rd_fire && hit_ccsr) |-> (READDATA[7:6] == 2'b00))
        else $error("reserved capture control bits nonzero");
endmodule : pat_timer
`default_nettype wire

//--- pat_timer_bench.sv
// register-level testbench for the auto-reload pwm timer
`timescale 1ns/1ns
`default_nettype none
module pat_timer_bench;
    logic        clk = 1'b0;       // 100 MHz cpu clock
    logic        rst_n = 1'b0;     // reset, active low
    logic [9:0]  address = 10'h000; // bus byte address
    logic        rd = 1'b0;        // bus read
    logic        wr = 1'b0;        // bus write
    logic [31:0] wdata = 32'h0;    // bus write data
    logic [31:0] rdata;            // bus read data
    logic        waitreq;          // bus wait
    logic        ovf_irq;          // overflow request
    logic        ext_clk;          // external clock pin
    logic        ext_run = 1'b0;   // external clock on
    logic [1:0]  cap_in;           // capture pins
    logic [1:0]  cap_lvl = 2'h2;   // requested capture levels
    logic [1:0]  cap_irq;          // capture requests
    logic [3:0]  pwm_out;          // pwm levels
    logic [3:0]  pwm_oe;           // pwm enables
    logic [31:0] got;              // last read value
    int          n_mismatch = 0;   // mismatches seen
    int          checks_done = 0;  // comparisons made
    always #5 clk = ~clk;
    pat_timer i_pat_timer (.REF_CLK(clk), .RST_N(rst_n), .ADDRESS(address), .READ(rd),
        .WRITE(wr), .BYTEENABLE(4'hf), .WRITEDATA(wdata), .READDATA(rdata),
        .WAITREQUEST(waitreq), .EXT_CLK(ext_clk), .CAP_IN(cap_in), .PWM_OUT(pwm_out),
        .PWM_OE(pwm_oe), .OVF_IRQ(ovf_irq), .CAP_IRQ(cap_irq));
    pat_pin_model i_pat_pin_model (.clk(clk), .cap_lvl(cap_lvl), .ext_run(ext_run),
        .cap_pin(cap_in), .ext_clk(ext_clk));
    // ==========================================================
    // verdict and run end
    task automatic conclude;
        $display("counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    // ==========================================================
    // one bus access, held until wait drops, bounded
    task automatic access(input logic we, input logic [7:0] idx, input logic [7:0] data);
        int n;
        @(posedge clk);
        address <= {idx, 2'h0};
        wdata <= {24'h0, data};
        wr <= we;
        rd <= ~we;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (waitreq === 1'b0) break;
        end
        if (n == 50) begin
            n_mismatch++;
            conclude();
        end
        got = rdata; // read data stand at the edge that sees wait low
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : access
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        access(1'b0, idx, 8'h00);
        check(got, {24'h0, exp});
    endtask : rd_chk
    // ==========================================================
    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (logic [7:0] i = 8'h73; i <= 8'h7d; i++) rd_chk(i, 8'h00);
        rd_chk(8'h00, 8'h00); // unmapped index
        $display("test reset_values done");
        access(1'b1, pat_pkg::IDX_CCSR, 8'hff);
        rd_chk(pat_pkg::IDX_CCSR, 8'h3c);
        access(1'b1, pat_pkg::IDX_CAPV1, 8'h55);
        rd_chk(pat_pkg::IDX_CAPV1, 8'h00);
        $display("test access_kinds done");
        access(1'b1, pat_pkg::IDX_DUTY0, 8'h90);
        access(1'b1, pat_pkg::IDX_OCTL, 8'h10);
        access(1'b1, pat_pkg::IDX_ARR, 8'h80);
        access(1'b1, pat_pkg::IDX_CSR, 8'h72);
        access(1'b1, pat_pkg::IDX_CAR, 8'hff);
        access(1'b1, pat_pkg::IDX_CSR, 8'h7a); // run, divide by 128
        repeat (140) @(posedge clk);
        check(ovf_irq, 1);
        rd_chk(pat_pkg::IDX_CAR, 8'h80);
        rd_chk(pat_pkg::IDX_CSR, 8'h7b);
        rd_chk(pat_pkg::IDX_CSR, 8'h7a);
        check(pwm_out, 4'h1);
        check(pwm_oe, 4'h1);
        access(1'b1, pat_pkg::IDX_CAR, 8'h33);
        access(1'b1, pat_pkg::IDX_CSR, 8'h76); // stop and force reload
        rd_chk(pat_pkg::IDX_CAR, 8'h80);
        check(ovf_irq, 0);
        repeat (300) @(posedge clk);
        rd_chk(pat_pkg::IDX_CAR, 8'h80);
        access(1'b1, pat_pkg::IDX_OCTL, 8'h11);
        repeat (2) @(posedge clk);
        check(pwm_out, 4'h0);
        access(1'b1, pat_pkg::IDX_CAR, 8'h95);
        repeat (2) @(posedge clk);
        check(pwm_out, 4'h1);
        $display("test overflow_pwm done");
        access(1'b1, pat_pkg::IDX_CCSR, 8'h14);
        cap_lvl <= 2'h3; // ch1 rises
        repeat (8) @(posedge clk);
        check(cap_irq, 2'h1);
        rd_chk(pat_pkg::IDX_CCSR, 8'h15);
        rd_chk(pat_pkg::IDX_CAPV1, 8'h95);
        rd_chk(pat_pkg::IDX_CCSR, 8'h14);
        cap_lvl <= 2'h1; // ch2 falls
        repeat (8) @(posedge clk);
        check(cap_irq, 2'h0);
        rd_chk(pat_pkg::IDX_CCSR, 8'h16);
        rd_chk(pat_pkg::IDX_CAPV2, 8'h95);
        $display("test capture done");
        access(1'b1, pat_pkg::IDX_CAR, 8'h00);
        access(1'b1, pat_pkg::IDX_CSR, 8'h88); // external source, run
        repeat (20) @(posedge clk);
        rd_chk(pat_pkg::IDX_CAR, 8'h00);
        ext_run <= 1'b1;
        repeat (64) @(posedge clk);
        // eight pin rises, each counted three edges later
        rd_chk(pat_pkg::IDX_CAR, 8'h08);
        ext_run <= 1'b0;
        $display("test external_clock done");
        conclude();
    end
endmodule : pat_timer_bench
`default_nettype wire
